/* inc/tw_pkg.sv */
// constants, field positions and state type of the two-wire master
// assumes a 25 MHz system clock and an apb slave port on the host side
// How it works
// - status reads with low prescaler bits zero
// - start waits until the bus is free
// - start sent: flag set, code 0x08
// - address direction bit picks transmit or receive
// - read address gives 0x38, 0x40 or 0x48
// - received byte held while flag is set
// - stop request sends stop, then self-clears
// - repeated start keeps bus, reports 0x10
// - sent data byte reports 0x28, 0x30 or 0x38
// - clear with start only: repeated start
// - clear with stop only: stop, self-clear
// - start and stop: stop, then new start
// - lost arbitration reports 0x38
// - in 0x38: release bus, or restart
// - writing one clears flag, resumes transfer
// - data write with flag low: collision
package tw_pkg;
    // register byte offsets on the apb
    localparam logic [7:0] TW_OFS_CTRL = 8'h00;
    localparam logic [7:0] TW_OFS_STAT = 8'h04;
    localparam logic [7:0] TW_OFS_DATA = 8'h08;
    // control register bit positions
    localparam int TW_B_FLAG = 7;
    localparam int TW_B_ACK  = 6;
    localparam int TW_B_STA  = 5;
    localparam int TW_B_STO  = 4;
    localparam int TW_B_WC   = 3;
    localparam int TW_B_EN   = 2;
    localparam int TW_B_IE   = 0;
    // status codes, low three bits always zero
    localparam logic [7:0] TW_C_START = 8'h08;
    localparam logic [7:0] TW_C_RSTRT = 8'h10;
    localparam logic [7:0] TW_C_AW_AK = 8'h18;
    localparam logic [7:0] TW_C_AW_NK = 8'h20;
    localparam logic [7:0] TW_C_DT_AK = 8'h28;
    localparam logic [7:0] TW_C_DT_NK = 8'h30;
    localparam logic [7:0] TW_C_LOST  = 8'h38;
    localparam logic [7:0] TW_C_AR_AK = 8'h40;
    localparam logic [7:0] TW_C_AR_NK = 8'h48;
    localparam logic [7:0] TW_C_DR_AK = 8'h50;
    localparam logic [7:0] TW_C_DR_NK = 8'h58;
    localparam logic [7:0] TW_C_IDLE  = 8'hf8;
    // timing: scl period and system clock period in ns
    localparam int TW_SCL_NS  = 320;
    localparam int TW_CLK_NS  = 40;
    localparam int TW_QTR_RAW = TW_SCL_NS / (4 * TW_CLK_NS);
    localparam int TW_QTR_CYC = (TW_QTR_RAW < 1) ? 1 : TW_QTR_RAW;
    // bit sequencer: quarter in which scl is high, ack bit index
    localparam logic [1:0] TW_Q_HIGH = 2'h2;
    localparam logic [3:0] TW_ACKBIT = 4'h8;
    // engine states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_WFREE = 7'h02,
        ST_START = 7'h04,
        ST_BIT   = 7'h08,
        ST_STOP  = 7'h10,
        ST_HOLD  = 7'h20,
        ST_LOST  = 7'h40
    } tw_state_t;
endpackage

/* logic/tw_master.sv */
// two-wire bus master engine with apb register port
// assumes open-drain pads outside and a pull-up on both lines
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps
module tw_master
    import tw_pkg::*;
#(
    parameter int QTR_CYC = TW_QTR_CYC  // system clocks per scl quarter
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output wire logic        PREADY,
    output wire logic        PSLVERR,
    input  wire logic        SCL_I,
    output wire logic        SCL_O,
    output wire logic        SCL_OE,
    input  wire logic        SDA_I,
    output wire logic        SDA_O,
    output wire logic        SDA_OE
);
    localparam int CW = (QTR_CYC > 1) ? $clog2(QTR_CYC) : 1;

    // pin synchronisers and bus monitor
    logic [1:0] scl_sy_r;            // scl two-stage sync
    logic [1:0] sda_sy_r;            // sda two-stage sync
    logic       sda_p_r;             // previous synced sda
    logic       busy_r;              // someone owns the bus
    // divider
    logic [CW-1:0] cnt_r;            // quarter divider
    // engine registers
    tw_state_t  state_r, state_nxt;
    logic [1:0] q_r, q_nxt;          // quarter within a bit
    logic [3:0] bit_r, bit_nxt;      // bit index, 8 is ack
    logic [7:0] shift_r, shf_nxt;    // data register / shifter
    logic [7:0] code_r, code_nxt;    // status code
    logic       smp_r, smp_nxt;      // sda sampled at scl high
    logic       own_r, own_nxt;      // we hold the bus
    logic       rx_r, rx_nxt;        // master receive mode
    logic       adr_r, adr_nxt;      // next byte is address
    logic       scl_oe_r, scl_oe_nxt;
    logic       sda_oe_r, sda_oe_nxt;
    logic       hw_set;              // engine raises the flag
    logic       sto_clr;             // engine ends stop request
    // control bits
    logic       flag_r;              // transfer done flag
    logic       ack_en_r;            // ack enable
    logic       sta_r;               // start request
    logic       sto_r;               // stop request
    logic       wc_r;                // write collision
    logic       en_r;                // interface enable
    logic       ie_r;                // interrupt enable, kept only

    // synced pin levels, second stage only
    wire scl_s = scl_sy_r[1];
    wire sda_s = sda_sy_r[1];

    // apb decode
    wire acc      = PSEL & PENABLE;
    wire wr       = acc & PWRITE;
    wire rd_setup = PSEL & ~PENABLE & ~PWRITE;
    wire hit_ctrl = (PADDR == TW_OFS_CTRL);
    wire hit_stat = (PADDR == TW_OFS_STAT);
    wire hit_data = (PADDR == TW_OFS_DATA);
    wire hit      = hit_ctrl | hit_stat | hit_data;
    wire ctrl_wr  = wr & hit_ctrl;
    wire data_wr  = wr & hit_data;
    // writing one to the flag bit clears it and resumes
    wire flag_clr = ctrl_wr & PWDATA[TW_B_FLAG] & flag_r;
    // data writes only land while the flag is up
    wire data_ok  = data_wr & flag_r;
    wire data_bad = data_wr & ~flag_r;

    // zero-wait slave; unmapped offsets answer with an error
    assign PREADY  = 1'b1;
    assign PSLVERR = acc & ~hit;

    // control image, fixed bit order
    wire [7:0] ctrl_img = {flag_r, ack_en_r, sta_r, sto_r,
                           wc_r, en_r, 1'b0, ie_r};
    // prescaler field masked: low three bits read zero
    wire [7:0] stat_img = {code_r[7:3], 3'b000};
    wire [7:0] rd_mux   = hit_ctrl ? ctrl_img :
                          hit_stat ? stat_img :
                          hit_data ? shift_r  : 8'h00;

    // open-drain: only ever pull low
    assign SCL_O  = 1'b0;
    assign SDA_O  = 1'b0;
    assign SCL_OE = scl_oe_r;
    assign SDA_OE = sda_oe_r;

    // quarter tick, and a step that waits out clock stretching
    wire tick = (cnt_r == CW'(QTR_CYC - 1));
    wire step = tick & ((q_r != TW_Q_HIGH) | scl_s);
    // bus conditions seen on the synced lines
    wire see_start = scl_s & sda_p_r & ~sda_s;
    wire see_stop  = scl_s & ~sda_p_r & sda_s;
    // address and master transmit bytes are driven by us
    wire tx_now  = adr_r | ~rx_r;
    wire is_ack  = (bit_r == TW_ACKBIT);
    // level to pull on sda for this bit
    wire drive_lo = is_ack ? (~tx_now & ack_en_r)
                           : (tx_now & ~shift_r[7]);
    // we let sda float but somebody else pulled it low
    wire lost_now = ~sda_oe_r & ~sda_s & (is_ack ? ~tx_now : tx_now);

    // status code after the ack bit of a byte
    wire [7:0] aw_code = smp_r ? TW_C_AW_NK : TW_C_AW_AK;
    wire [7:0] ar_code = smp_r ? TW_C_AR_NK : TW_C_AR_AK;
    wire [7:0] dt_code = smp_r ? TW_C_DT_NK : TW_C_DT_AK;
    wire [7:0] dr_code = smp_r ? TW_C_DR_NK : TW_C_DR_AK;
    wire [7:0] adr_code = shift_r[0] ? ar_code : aw_code;
    wire [7:0] dat_code = rx_r ? dr_code : dt_code;
    wire [7:0] end_code = adr_r ? adr_code : dat_code;

    // input synchronisers and bus-busy tracking
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            scl_sy_r <= 2'b11;
            sda_sy_r <= 2'b11;
            sda_p_r  <= 1'b1;
            busy_r   <= 1'b0;
        end else begin
            scl_sy_r <= {scl_sy_r[0], SCL_I};
            sda_sy_r <= {sda_sy_r[0], SDA_I};
            sda_p_r  <= sda_s;
            // a start marks the bus taken, a stop frees it
            if (see_start)
                busy_r <= 1'b1;
            else if (see_stop || !en_r)
                busy_r <= 1'b0;
        end
    end

    // free-running quarter divider
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N)
            cnt_r <= '0;
        else
            cnt_r <= tick ? '0 : cnt_r + CW'(1);
    end

    // bus engine, one quarter of a bit per step
    always_comb begin
        state_nxt  = state_r;
        q_nxt      = q_r;
        bit_nxt    = bit_r;
        shf_nxt    = shift_r;
        code_nxt   = code_r;
        smp_nxt    = smp_r;
        own_nxt    = own_r;
        rx_nxt     = rx_r;
        adr_nxt    = adr_r;
        scl_oe_nxt = scl_oe_r;
        sda_oe_nxt = sda_oe_r;
        hw_set     = 1'b0;
        sto_clr    = 1'b0;
        case (state_r)
            ST_IDLE: begin
                // bus released; a pending start request launches
                scl_oe_nxt = 1'b0;
                sda_oe_nxt = 1'b0;
                own_nxt    = 1'b0;
                code_nxt   = TW_C_IDLE;
                if (sta_r && !flag_r)
                    state_nxt = ST_WFREE;
            end
            ST_WFREE: begin
                // never break into another master's frame
                if (!busy_r && tick) begin
                    state_nxt = ST_START;
                    q_nxt     = 2'h0;
                end
            end
            ST_START: begin
                if (step) begin
                    q_nxt = q_r + 2'h1;
                    case (q_r)
                        2'h0: sda_oe_nxt = 1'b0;   // sda up, scl low
                        2'h1: scl_oe_nxt = 1'b0;   // scl up
                        2'h2: sda_oe_nxt = 1'b1;   // sda falls: start
                        default: begin
                            scl_oe_nxt = 1'b1;
                            // second start while owning is repeated
                            code_nxt  = own_r ? TW_C_RSTRT
                                              : TW_C_START;
                            own_nxt   = 1'b1;
                            adr_nxt   = 1'b1;
                            hw_set    = 1'b1;
                            state_nxt = ST_HOLD;
                        end
                    endcase
                end
            end
            ST_BIT: begin
                if (step) begin
                    q_nxt = q_r + 2'h1;
                    case (q_r)
                        2'h0: sda_oe_nxt = drive_lo;
                        2'h1: scl_oe_nxt = 1'b0;
                        2'h2: begin
                            smp_nxt = sda_s;
                            if (!is_ack)
                                shf_nxt = {shift_r[6:0], sda_s};
                            if (lost_now) begin
                                // drop both lines, wait in the lost state
                                scl_oe_nxt = 1'b0;
                                sda_oe_nxt = 1'b0;
                                own_nxt    = 1'b0;
                                code_nxt   = TW_C_LOST;
                                hw_set     = 1'b1;
                                state_nxt  = ST_LOST;
                            end
                        end
                        default: begin
                            scl_oe_nxt = 1'b1;
                            if (is_ack) begin
                                // sda freed in the same step that pulls scl low
                                sda_oe_nxt = 1'b0;
                                code_nxt   = end_code;
                                hw_set     = 1'b1;
                                if (adr_r)
                                    rx_nxt = shift_r[0];
                                adr_nxt    = 1'b0;
                                state_nxt  = ST_HOLD;
                            end else begin
                                bit_nxt = bit_r + 4'h1;
                            end
                        end
                    endcase
                end
            end
            ST_HOLD: begin
                // scl held low; shifter untouched while flag is up
                scl_oe_nxt = 1'b1;
                if (flag_clr) begin
                    q_nxt   = 2'h0;
                    bit_nxt = 4'h0;
                    if (PWDATA[TW_B_STO])
                        state_nxt = ST_STOP;
                    else if (PWDATA[TW_B_STA])
                        state_nxt = ST_START;
                    else
                        state_nxt = ST_BIT;
                end
            end
            ST_LOST: begin
                // bus let go; flag clear idles, a set start waits
                scl_oe_nxt = 1'b0;
                sda_oe_nxt = 1'b0;
                if (flag_clr)
                    state_nxt = ST_IDLE;
            end
            ST_STOP: begin
                if (step) begin
                    q_nxt = q_r + 2'h1;
                    case (q_r)
                        2'h0: sda_oe_nxt = 1'b1;   // sda low, scl low
                        2'h1: scl_oe_nxt = 1'b0;   // scl up
                        2'h2: sda_oe_nxt = 1'b0;   // sda rises: stop
                        default: begin
                            sto_clr   = 1'b1;
                            own_nxt   = 1'b0;
                            code_nxt  = TW_C_IDLE;
                            state_nxt = ST_IDLE;
                        end
                    endcase
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        // disabling drops the bus at once, whatever the state
        if (!en_r) begin
            state_nxt  = ST_IDLE;
            scl_oe_nxt = 1'b0;
            sda_oe_nxt = 1'b0;
            own_nxt    = 1'b0;
        end
    end

    // engine state registers
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            state_r  <= ST_IDLE;
            q_r      <= 2'h0;
            bit_r    <= 4'h0;
            code_r   <= TW_C_IDLE;
            smp_r    <= 1'b1;
            own_r    <= 1'b0;
            rx_r     <= 1'b0;
            adr_r    <= 1'b0;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            q_r      <= q_nxt;
            bit_r    <= bit_nxt;
            code_r   <= code_nxt;
            smp_r    <= smp_nxt;
            own_r    <= own_nxt;
            rx_r     <= rx_nxt;
            adr_r    <= adr_nxt;
            scl_oe_r <= scl_oe_nxt;
            sda_oe_r <= sda_oe_nxt;
        end
    end

    // data register: software load only while flag is up
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N)
            shift_r <= 8'hff;
        else if (data_ok)
            shift_r <= PWDATA[7:0];
        else
            shift_r <= shf_nxt;
    end

    // flag: a hardware set in the same cycle beats the clear
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N)
            flag_r <= 1'b0;
        else if (hw_set)
            flag_r <= 1'b1;
        else if (flag_clr)
            flag_r <= 1'b0;
    end

    // write collision: set on a refused write, cleared by a good one
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N)
            wc_r <= 1'b0;
        else if (data_bad)
            wc_r <= 1'b1;
        else if (data_ok)
            wc_r <= 1'b0;
    end

    // control bits; a write beats the stop self-clear, never lost
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ack_en_r <= 1'b0;
            sta_r    <= 1'b0;
            sto_r    <= 1'b0;
            en_r     <= 1'b0;
            ie_r     <= 1'b0;
        end else if (ctrl_wr) begin
            ack_en_r <= PWDATA[TW_B_ACK];
            sta_r    <= PWDATA[TW_B_STA];
            sto_r    <= PWDATA[TW_B_STO];
            en_r     <= PWDATA[TW_B_EN];
            ie_r     <= PWDATA[TW_B_IE];
        end else if (sto_clr) begin
            sto_r    <= 1'b0;
        end
    end

    // read data captured in the setup cycle, shown in access
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N)
            PRDATA <= 32'h0000_0000;
        else if (rd_setup)
            PRDATA <= {24'h00_0000, rd_mux};
    end
endmodule

/* test/tw_master_assertions.sv */
// port-level concurrent checks for the two-wire master
// assumes it is bound into tw_master and sees only that module's ports
`timescale 1ns/100ps
module tw_master_assertions
    import tw_pkg::*;
#(
    parameter int QTR_CYC = TW_QTR_CYC  // system clocks per scl quarter
) (
    input wire logic        CLK_SYS,
    input wire logic        RST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PSLVERR,
    input wire logic        SCL_O,
    input wire logic        SCL_OE,
    input wire logic        SDA_O,
    input wire logic        SDA_OE
);
    // longest wait from start edge to clock low, a generous margin
    localparam int HOLD_MAX = 16 * QTR_CYC + 8;
    // one register at each of the three word offsets
    wire logic mapped = (PADDR == TW_OFS_CTRL) || (PADDR == TW_OFS_STAT)
                        || (PADDR == TW_OFS_DATA);
    // read data is latched in the setup cycle
    wire logic rd_setup = PSEL && !PENABLE && !PWRITE;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    stat_low_a: assert property (rd_setup && PADDR == TW_OFS_STAT |=>
        PRDATA[2:0] == 3'h0 && PRDATA[31:8] == 24'h0)
        else $error("status read shows nonzero low bits");
    err_map_a: assert property (PSEL && PENABLE |-> PSLVERR == !mapped)
        else $error("error response does not match the map");
    rd_unmap_a: assert property (rd_setup && !mapped |=> PRDATA == 32'h0)
        else $error("unmapped read returned data");
    rd_hold_a: assert property (!rd_setup |=> $stable(PRDATA))
        else $error("read data changed without a read");
    od_zero_a: assert property (SCL_O == 1'b0 && SDA_O == 1'b0)
        else $error("open-drain output drives high");
    // clock phases never shrink to a single cycle
    scl_high_a: assert property ($fell(SCL_OE) |=> !SCL_OE)
        else $error("clock released for one cycle only");
    scl_low_a: assert property ($rose(SCL_OE) |=> SCL_OE)
        else $error("clock low phase too short");
    // start: data falls with clock high, then clock low with data held
    start_hold_a: assert property ($rose(SDA_OE) && !SCL_OE |->
        (SDA_OE throughout (##[1:HOLD_MAX] SCL_OE)))
        else $error("start not completed by clock low");
    // stop: data rises only after the clock was already released
    stop_form_a: assert property ($fell(SDA_OE) && !SCL_OE |->
        !$past(SCL_OE))
        else $error("data released together with clock");
endmodule

bind tw_master tw_master_assertions #(.QTR_CYC(QTR_CYC)) chk (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_O(SDA_O), .SDA_OE(SDA_OE));

/* test/tw_slave_model.sv */
// behavioural slave on the two-wire bus: acks its address, takes or
// sends bytes; assumes resolved line levels with pull-ups outside
`timescale 1ns/100ps
module tw_slave_model #(
    parameter logic [6:0] ADDR = 7'h52, // address the model answers
    parameter logic [7:0] TX0  = 8'hc3  // first byte sent on a read
) (
    input  wire logic scl,    // resolved clock line
    input  wire logic sda,    // resolved data line
    input  wire logic nak,    // refuse write data when high
    output logic      sda_oe  // high pulls data low
);
    logic [3:0] bitn  = 4'he;  // bit index, e idle, f just after start
    logic [7:0] sh;            // incoming shift register
    logic [7:0] tx    = TX0;   // byte being sent
    logic       first = 1'b0;  // address byte of this transfer
    logic       hit   = 1'b0;  // our address was seen
    logic       rd    = 1'b0;  // read direction
    logic       send  = 1'b0;  // driving a byte
    logic       mack;          // master acked the last byte

    initial sda_oe = 1'b0;
    // start: restart the count; stop: drop off the bus
    always @(negedge sda) if (scl) begin
        bitn = 4'hf;
        first = 1'b1;
        hit = 1'b0;
    end
    always @(posedge sda) if (scl) begin
        bitn = 4'he;
        hit = 1'b0;
        send = 1'b0;
        sda_oe <= 1'b0;
    end
    // sample while clock high
    always @(posedge scl) begin
        if (bitn < 4'h8) sh = {sh[6:0], sda};
        else mack = !sda;
    end
    // data changes only while clock low, so no false start or stop
    always @(negedge scl) begin
        if (bitn == 4'hf) begin
            bitn = 4'h0;
        end else if (bitn == 4'h7) begin
            if (first) begin
                hit = (sh[7:1] == ADDR);
                rd = sh[0];
            end
            sda_oe <= hit && (first || (!rd && !nak));
            bitn = 4'h8;
        end else if (bitn == 4'h8) begin
            // a read goes on only while the master keeps acking
            send = hit && rd && (first || mack);
            if (send && !first) tx = tx + 8'h01;
            first = 1'b0;
            sda_oe <= send && !tx[7];
            bitn = 4'h0;
        end else if (bitn < 4'h7) begin
            sda_oe <= send && !tx[3'd6 - bitn[2:0]];
            bitn = bitn + 4'h1;
        end
    end
endmodule

/* test/two_wire_master_txrx_tb.sv */
// self-checking bench: apb register tasks drive the two-wire master
// assumes the slave model and the bound checker are compiled with it
`timescale 1ns/100ps
module two_wire_master_txrx_tb
    import tw_pkg::*;
;
    localparam logic [7:0]  SLV  = 8'ha4;   // slave address 0x52, write
    localparam logic [31:0] GO   = 32'ha4;  // flag, start, enable
    localparam logic [31:0] CONT = 32'h84;  // flag, enable
    localparam logic [31:0] CACK = 32'hc4;  // flag, ack enable, enable
    localparam logic [31:0] STOP = 32'h94;  // flag, stop, enable
    localparam logic [31:0] STSP = 32'hb4;  // flag, start, stop, enable
    logic        CLK_SYS;
    logic        RST_N    = 1'b0;
    logic        PSEL     = 1'b0;
    logic        PENABLE  = 1'b0;
    logic        PWRITE   = 1'b0;
    logic [7:0]  PADDR    = 8'h00;
    logic [31:0] PWDATA   = 32'h0;
    logic        rival_oe = 1'b0;  // another master pulling data low
    logic        nak      = 1'b0;  // slave refuses write data
    logic [31:0] rv;               // last read data
    logic        re;               // last error response
    int          failures  = 0;
    int          cmp_count = 0;
    wire logic [31:0] PRDATA;
    wire logic   PREADY, PSLVERR, SCL_O, SCL_OE, SDA_O, SDA_OE, slv_oe;
    // only the master drives the clock; data is a wired-and
    wire logic   scl_w = !SCL_OE;
    wire logic   sda_w = !(SDA_OE || slv_oe || rival_oe);

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

    initial begin
        CLK_SYS = 1'b0;
        forever #20 CLK_SYS = !CLK_SYS;
    end

    tw_master dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SCL_I(scl_w),
        .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_I(sda_w), .SDA_O(SDA_O),
        .SDA_OE(SDA_OE));
    tw_slave_model slv (.scl(scl_w), .sda(sda_w), .nak(nak),
        .sda_oe(slv_oe));

    // one apb transfer; a free edge first keeps strobes from double writes
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do @(posedge CLK_SYS); while (PREADY !== 1'b1);
        rv = PRDATA;
        re = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // read and compare under a mask
    task automatic rk(input logic [7:0] a, input logic [31:0] m, e);
        apb(1'b0, a, 32'h0);
        `CHK(rv & m, e)
    endtask
    // poll a control bit, bounded
    task automatic wt(input int b, input logic v);
        int n;
        n = 0;
        do begin
            apb(1'b0, TW_OFS_CTRL, 32'h0);
            n++;
        end while (rv[b] !== v && n < 500);
        `CHK(rv[b], v)
    endtask
    // control write, wait for the flag, check the code
    task automatic cw(input logic [31:0] c, input logic [7:0] s);
        apb(1'b1, TW_OFS_CTRL, c);
        wt(TW_B_FLAG, 1'b1);
        rk(TW_OFS_STAT, 32'hff, {24'h0, s});
    endtask
    task automatic step(input logic [7:0] d, input logic [31:0] c,
                        input logic [7:0] s);
        apb(1'b1, TW_OFS_DATA, {24'h0, d});
        cw(c, s);
    endtask
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog, far beyond the expected few thousand cycles
    initial begin
        #2000000;
        failures++;
        final_report;
    end

    initial begin
        repeat (4) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        rk(TW_OFS_CTRL, 32'hffffffff, 32'h0);
        rk(TW_OFS_STAT, 32'hffffffff, 32'hf8);
        rk(TW_OFS_DATA, 32'hffffffff, 32'hff);
        rk(8'h0c, 32'hffffffff, 32'h0);
        `CHK(re, 1'b1)
        // data write while the flag is low is refused
        apb(1'b1, TW_OFS_DATA, 32'h5a);
        rk(TW_OFS_CTRL, 32'h08, 32'h08);
        rk(TW_OFS_DATA, 32'hff, 32'hff);
        // bus already taken: the start must wait for the stop;
        // busy tracking only runs while the interface is enabled
        apb(1'b1, TW_OFS_CTRL, 32'h04);
        rk(TW_OFS_CTRL, 32'hff, 32'h0c);
        rival_oe <= 1'b1;
        repeat (4) @(posedge CLK_SYS);
        apb(1'b1, TW_OFS_CTRL, GO);
        repeat (30) @(posedge CLK_SYS);
        rk(TW_OFS_CTRL, 32'h80, 32'h0);
        `CHK(SCL_OE, 1'b0)
        rival_oe <= 1'b0;
        wt(TW_B_FLAG, 1'b1);
        rk(TW_OFS_STAT, 32'hff, 32'h08);
        // transmit: address, acked byte, refused byte
        step(SLV, CONT, TW_C_AW_AK);
        step(8'h3c, CONT, TW_C_DT_AK);
        rk(TW_OFS_DATA, 32'hff, 32'h3c);
        nak <= 1'b1;
        step(8'h96, CONT, TW_C_DT_NK);
        nak <= 1'b0;
        // repeated start, then read two bytes, nack on the last
        step(8'h00, GO, TW_C_RSTRT);
        step(SLV | 8'h01, CONT, TW_C_AR_AK);
        cw(CACK, TW_C_DR_AK);
        rk(TW_OFS_DATA, 32'hff, 32'hc3);
        cw(CONT, TW_C_DR_NK);
        rk(TW_OFS_DATA, 32'hff, 32'hc4);
        apb(1'b1, TW_OFS_CTRL, STOP);
        wt(TW_B_STO, 1'b0);
        rk(TW_OFS_STAT, 32'hff, {24'h0, TW_C_IDLE});
        // read of an absent slave, then stop followed by start
        cw(GO, TW_C_START);
        step(8'h31, CONT, TW_C_AR_NK);
        cw(STSP, TW_C_START);
        rk(TW_OFS_CTRL, 32'h10, 32'h0);
        step(8'h30, CONT, TW_C_AW_NK);
        // a rival holds data low while we send ones
        rival_oe <= 1'b1;
        step(8'hff, CONT, TW_C_LOST);
        `CHK({SCL_OE, SDA_OE}, 2'b00)
        rival_oe <= 1'b0;
        apb(1'b1, TW_OFS_CTRL, CONT);
        repeat (20) @(posedge CLK_SYS);
        rk(TW_OFS_STAT, 32'hff, {24'h0, TW_C_IDLE});
        `CHK({SCL_OE, SDA_OE}, 2'b00)
        final_report;
    end
endmodule
